// >>> core/iwd_decode.sv
`timescale 1ns/1ps
`default_nettype none
module iwd_decode (
  input  wire logic                           clk_sys,
  input  wire logic                           nrst,
  input  wire logic [iwd_pkg::IWD_WORD_W-1:0] instr_word,  // Fetched word, same domain
  input  wire logic                           skip_true,   // Datapath: condition met, valid in last phase
  output logic [iwd_pkg::IWD_WORD_W-1:0]      exec_word,   // Word being executed
  output var iwd_pkg::iwd_class_t             exec_class,  // Byte, bit or literal group
  output logic [iwd_pkg::IWD_FILE_W-1:0]      file_addr,   // Operand register in the bank
  output logic                                dest_is_file,// Destination select bit
  output logic                                wr_w,        // Result goes to W
  output logic                                wr_file,     // Result goes to file
  output logic [iwd_pkg::IWD_BIT_W-1:0]       bit_index,   // Bit acted on
  output logic [7:0]                          bit_mask,    // One-hot of bit_index
  output logic [iwd_pkg::IWD_LIT11_W-1:0]     literal,     // Constant operand, zero-extended
  output logic                                lit_is_11,   // Literal carries a branch target
  output logic [1:0]                          phase,       // Oscillator period 0..3
  output logic                                cycle_end,   // Last period of a cycle
  output logic                                fetch_req,   // Take next word at cycle end
  output logic                                nop_cycle    // Flushed second cycle
);
  import iwd_pkg::*;

  iwd_fields_if fi ();
  iwd_fields u_fields (
    .f (fi)
  );

  // State registers
  logic [IWD_WORD_W-1:0] word_reg, word_next;   // Latched word
  logic [1:0]            ph_reg, ph_next;       // Period counter
  logic                  nop_reg, nop_next;     // Current cycle is a NOP

  assign fi.word = word_reg;

  // Check-only helpers: fields re-derived from the raw word so the extractor is not trusted
  logic [1:0] chk_grp;  // Group bits of the executing word
  logic [3:0] chk_sub;  // Byte-group sub-code
  logic       chk_skop; // Executing word is a conditional skip opcode
  assign chk_grp  = exec_word[IWD_WORD_W-1:IWD_GRP_LSB];
  assign chk_sub  = exec_word[IWD_GRP_LSB-1:IWD_SUB_LSB];
  assign chk_skop = ((chk_grp == IWD_GRP_BYTE) && ((chk_sub == IWD_OP_DECSZ) || (chk_sub == IWD_OP_INCSZ))) ||
                    ((chk_grp == IWD_GRP_BIT) && exec_word[IWD_GRP_LSB-1]);

  // Next-state: period counter wraps each four periods; new word only at the wrap
  always_comb begin
    ph_next   = ph_reg + 2'h1;
    word_next = word_reg;
    nop_next  = nop_reg;
    if (ph_reg == IWD_PH_LAST) begin
      if (nop_reg) begin
        // Flush cycle over, resume normal fetch
        nop_next  = 1'b0;
        word_next = instr_word;
      end else if (fi.is_jump || (fi.may_skip && skip_true)) begin
        // Second cycle runs as NOP; prefetched word is discarded
        nop_next  = 1'b1;
      end else begin
        word_next = instr_word;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      word_reg <= '0;
      ph_reg   <= 2'h0;
      nop_reg  <= 1'b0;
    end else begin
      word_reg <= word_next;
      ph_reg   <= ph_next;
      nop_reg  <= nop_next;
    end
  end

  // Outputs; a NOP cycle suppresses every write
  always_comb begin
    exec_word    = word_reg;
    exec_class   = fi.cls;
    file_addr    = fi.faddr;
    dest_is_file = fi.dest_f;
    wr_w         = !nop_reg && (fi.cls == IWD_CLS_BYTE) && !fi.dest_f;
    wr_file      = !nop_reg && (fi.cls == IWD_CLS_BYTE) && fi.dest_f;
    bit_index    = fi.bidx;
    bit_mask     = 8'h01 << fi.bidx;
    literal      = fi.lit;
    lit_is_11    = fi.is_jump;
    phase        = ph_reg;
    cycle_end    = (ph_reg == IWD_PH_LAST);
    fetch_req    = cycle_end && (nop_next == 1'b0);
    nop_cycle    = nop_reg;
  end

  // Checks
  property p_phase_wrap;
    @(posedge clk_sys) disable iff (!nrst)
      (ph_reg == IWD_PH_LAST) |=> (ph_reg == 2'h0) ##3 (ph_reg == IWD_PH_LAST);
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("cycle is not four periods");

  property p_jump_nop;
    @(posedge clk_sys) disable iff (!nrst)
      (cycle_end && !nop_reg && fi.is_jump) |=> nop_reg [*4] ##1 !nop_reg;
  endproperty
  a_jump_nop: assert property (p_jump_nop) else $error("branch lacks one NOP cycle");

  property p_word_hold;
    @(posedge clk_sys) disable iff (!nrst)
      !cycle_end |=> $stable(word_reg);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word changed mid cycle");

  property p_dest;
    @(posedge clk_sys) disable iff (!nrst)
      (exec_class == IWD_CLS_BYTE && !nop_reg) |-> (wr_file == exec_word[IWD_DEST_POS]) && (wr_w != wr_file);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_faddr;
    @(posedge clk_sys) disable iff (!nrst)
      file_addr == exec_word[IWD_FILE_W-1:0];
  endproperty
  a_faddr: assert property (p_faddr) else $error("file address field wrong");

  property p_lit;
    @(posedge clk_sys) disable iff (!nrst)
      lit_is_11 ? (literal == exec_word[IWD_LIT11_W-1:0])
                : (literal == {3'h0, exec_word[IWD_LIT8_W-1:0]});
  endproperty
  a_lit: assert property (p_lit) else $error("literal field wrong");

  property p_class;
    @(posedge clk_sys) disable iff (!nrst)
      (exec_word[IWD_WORD_W-1:IWD_GRP_LSB] == IWD_GRP_BIT) |-> (exec_class == IWD_CLS_BIT) && (bit_mask[bit_index]);
  endproperty
  a_class: assert property (p_class) else $error("bit group decode wrong");

  property p_noskip;
    @(posedge clk_sys) disable iff (!nrst)
      (cycle_end && !nop_reg && !fi.is_jump && !skip_true) |=> !nop_reg;
  endproperty
  a_noskip: assert property (p_noskip) else $error("spurious NOP cycle");

  // A taken skip costs one flushed cycle, exactly like a branch
  property p_skip_nop;
    @(posedge clk_sys) disable iff (!nrst)
      (cycle_end && !nop_reg && chk_skop && skip_true) |=> nop_reg [*4] ##1 !nop_reg;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("taken skip lacks one NOP cycle");

  // Nothing may be written while the flushed cycle runs
  property p_nop_quiet;
    @(posedge clk_sys) disable iff (!nrst)
      nop_reg |-> (!wr_w && !wr_file);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("write during NOP cycle");

  // A fetch is only asked for in the last period of a cycle
  property p_fetch_end;
    @(posedge clk_sys) disable iff (!nrst)
      fetch_req |-> cycle_end;
  endproperty
  a_fetch_end: assert property (p_fetch_end) else $error("fetch outside last period");

  // A branch or a taken skip refuses the prefetched word
  property p_refuse;
    @(posedge clk_sys) disable iff (!nrst)
      (cycle_end && !nop_reg && ((chk_grp == IWD_GRP_JUMP) || (chk_skop && skip_true))) |-> !fetch_req;
  endproperty
  a_refuse: assert property (p_refuse) else $error("word taken after branch or skip");

  // The taken word is exactly what stood on the fetch input
  property p_word_take;
    @(posedge clk_sys) disable iff (!nrst)
      (cycle_end && fetch_req) |=> (exec_word == $past(instr_word));
  endproperty
  a_word_take: assert property (p_word_take) else $error("taken word not latched");

  // Both literal encodings sort into the literal and control group, with no register write
  property p_grp_lit;
    @(posedge clk_sys) disable iff (!nrst)
      ((chk_grp == IWD_GRP_JUMP) || (chk_grp == IWD_GRP_LIT)) |-> (exec_class == IWD_CLS_LIT) && !wr_w && !wr_file;
  endproperty
  a_grp_lit: assert property (p_grp_lit) else $error("literal group decode wrong");

  // The byte group keeps its class whatever the sub-code
  property p_grp_byte;
    @(posedge clk_sys) disable iff (!nrst)
      (chk_grp == IWD_GRP_BYTE) |-> (exec_class == IWD_CLS_BYTE);
  endproperty
  a_grp_byte: assert property (p_grp_byte) else $error("byte group decode wrong");

  // The bit index sits just above the file address
  property p_bit_idx;
    @(posedge clk_sys) disable iff (!nrst)
      bit_index == exec_word[IWD_BIT_LSB +: IWD_BIT_W];
  endproperty
  a_bit_idx: assert property (p_bit_idx) else $error("bit index field wrong");

  // Only call and jump carry the wide literal
  property p_lit_kind;
    @(posedge clk_sys) disable iff (!nrst)
      lit_is_11 == (chk_grp == IWD_GRP_JUMP);
  endproperty
  a_lit_kind: assert property (p_lit_kind) else $error("literal width select wrong");

  // Scenarios that should be seen at least once

  c_jump:  cover property (@(posedge clk_sys) disable iff (!nrst) cycle_end && fi.is_jump);
  c_skip:  cover property (@(posedge clk_sys) disable iff (!nrst) cycle_end && fi.may_skip && skip_true && !nop_reg);
  c_bit:   cover property (@(posedge clk_sys) disable iff (!nrst) exec_class == IWD_CLS_BIT);
  c_lit:   cover property (@(posedge clk_sys) disable iff (!nrst) exec_class == IWD_CLS_LIT && !lit_is_11);
  c_noskip: cover property (@(posedge clk_sys) disable iff (!nrst) cycle_end && chk_skop && !skip_true && !nop_reg);
endmodule
`default_nettype wire

// >>> core/iwd_fields.sv
`timescale 1ns/1ps
`default_nettype none
// Pure field split of one instruction word
module iwd_fields (
  iwd_fields_if.src f
);
  import iwd_pkg::*;
  logic [1:0] grp; // Top two bits pick the group
  // Decode stays purely combinational; the caller owns the word register
  always_comb begin
    grp        = f.word[IWD_WORD_W-1:IWD_GRP_LSB];
    f.faddr    = f.word[IWD_FILE_W-1:0];
    f.dest_f   = f.word[IWD_DEST_POS];
    f.bidx     = f.word[IWD_BIT_LSB +: IWD_BIT_W];
    f.is_jump  = (grp == IWD_GRP_JUMP);
    // Jumps carry 11 bits, the other literals 8
    if (f.is_jump) begin
      f.lit = f.word[IWD_LIT11_W-1:0];
    end else begin
      f.lit = {3'h0, f.word[IWD_LIT8_W-1:0]};
    end
    // Group sort; don't-care bits below are never compared
    case (grp)
      IWD_GRP_BYTE: f.cls = IWD_CLS_BYTE;
      IWD_GRP_BIT:  f.cls = IWD_CLS_BIT;
      default:      f.cls = IWD_CLS_LIT;
    endcase
    f.may_skip = ((grp == IWD_GRP_BYTE) &&
                  ((f.word[IWD_GRP_LSB-1:IWD_SUB_LSB] == IWD_OP_DECSZ) ||
                   (f.word[IWD_GRP_LSB-1:IWD_SUB_LSB] == IWD_OP_INCSZ))) ||
                 ((grp == IWD_GRP_BIT) &&
                  ((f.word[IWD_GRP_LSB-1:IWD_BIT_LSB+IWD_BIT_W] == IWD_BSUB_TSC) ||
                   (f.word[IWD_GRP_LSB-1:IWD_BIT_LSB+IWD_BIT_W] == IWD_BSUB_TSS)));
  end
endmodule
`default_nettype wire

// >>> core/iwd_if.sv
`timescale 1ns/1ps
`default_nettype none
// Fields carried from the field extractor to the sequencer
interface iwd_fields_if;
  import iwd_pkg::*;
  logic [IWD_WORD_W-1:0]  word;   // Raw word
  iwd_class_t             cls;    // Group
  logic [IWD_FILE_W-1:0]  faddr;  // File address
  logic                   dest_f; // Destination is file
  logic [IWD_BIT_W-1:0]   bidx;   // Bit index
  logic [IWD_LIT11_W-1:0] lit;    // Literal, zero-extended
  logic                   is_jump;// Call or goto
  logic                   may_skip;// Conditional skip opcode
  modport src (input word, output cls, faddr, dest_f, bidx, lit, is_jump, may_skip);
  modport dst (output word, input cls, faddr, dest_f, bidx, lit, is_jump, may_skip);
endinterface
`default_nettype wire

// >>> core/iwd_pkg.sv
`default_nettype none
package iwd_pkg;
  // Word geometry
  localparam int IWD_WORD_W     = 14;
  localparam int IWD_FILE_W     = 7;
  localparam int IWD_BIT_W      = 3;
  localparam int IWD_LIT8_W     = 8;
  localparam int IWD_LIT11_W    = 11;
  localparam int IWD_DEST_POS   = 7;
  localparam int IWD_BIT_LSB    = 7;
  localparam int IWD_GRP_LSB    = 12;
  localparam int IWD_GOTO_POS   = 11;
  localparam int IWD_SUB_LSB    = 8;
  // Group codes in the top two bits
  localparam logic [1:0] IWD_GRP_BYTE = 2'h0;
  localparam logic [1:0] IWD_GRP_BIT  = 2'h1;
  localparam logic [1:0] IWD_GRP_JUMP = 2'h2;
  localparam logic [1:0] IWD_GRP_LIT  = 2'h3;
  // Bit-oriented sub-codes in bits 11:10
  localparam logic [1:0] IWD_BSUB_TSC = 2'h2;
  localparam logic [1:0] IWD_BSUB_TSS = 2'h3;
  // Byte-oriented sub-codes in bits 11:8 that may skip
  localparam logic [3:0] IWD_OP_DECSZ = 4'hB;
  localparam logic [3:0] IWD_OP_INCSZ = 4'hF;
  // Oscillator periods per instruction cycle
  localparam int IWD_PHASES     = 4;
  localparam logic [1:0] IWD_PH_LAST = 2'h3;
  // Instruction class
  typedef enum logic [1:0] {
    IWD_CLS_BYTE = 2'b00,
    IWD_CLS_BIT  = 2'b01,
    IWD_CLS_LIT  = 2'b10
  } iwd_class_t;
endpackage
`default_nettype wire

// >>> test/iwd_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
module iwd_decode_test;
  import iwd_pkg::*;
  logic clk_sys, nrst, skip_true, dest_is_file, wr_w, wr_file, lit_is_11, cycle_end, fetch_req, nop_cycle;
  logic [13:0] instr_word, exec_word;
  logic [6:0]  file_addr;
  logic [2:0]  bit_index;
  logic [7:0]  bit_mask;
  logic [10:0] literal;
  logic [1:0]  phase;
  iwd_class_t  exec_class;
  int          n_fail, total_checks;
  // Program: byte, skip, bit, jump and literal cases; 9 and 10 differ only in a don't-care bit
  localparam logic [13:0] PROG [0:11] = '{14'h0785, 14'h0575, 14'h0BFF, 14'h0F80, 14'h1B85, 14'h1C00,
    14'h1000, 14'h2ABC, 14'h2123, 14'h3E5A, 14'h3F5A, 14'h3900};
  localparam logic [11:0] SKPV = 12'h074; // Skip outcome per word, bit i for word i; word 3 skips not
  iwd_decode u_iwd_decode (.clk_sys(clk_sys), .nrst(nrst), .instr_word(instr_word), .skip_true(skip_true),
    .exec_word(exec_word), .exec_class(exec_class), .file_addr(file_addr), .dest_is_file(dest_is_file),
    .wr_w(wr_w), .wr_file(wr_file), .bit_index(bit_index), .bit_mask(bit_mask), .literal(literal),
    .lit_is_11(lit_is_11), .phase(phase), .cycle_end(cycle_end), .fetch_req(fetch_req), .nop_cycle(nop_cycle));
  iwd_fetch_model u_iwd_fetch_model (.clk_sys(clk_sys), .nrst(nrst), .phase(phase), .fetch_req(fetch_req),
    .instr_word(instr_word), .skip_true(skip_true));
  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Waits for the take of word i, checks every field, then walks its one or two cycles
  task automatic run_word(input int i);
    logic [13:0] w;
    logic [1:0]  t;
    logic        two;
    int          n;
    w = PROG[i];
    t = w[13:12];
    two = (t == IWD_GRP_JUMP) || (SKPV[i] && (((t == IWD_GRP_BYTE) && (w[11:8] == IWD_OP_DECSZ ||
      w[11:8] == IWD_OP_INCSZ)) || ((t == IWD_GRP_BIT) && w[11])));
    n = 0;
    // Bounded wait for the taking edge
    while (!(phase === 2'h3 && fetch_req === 1'b1)) begin
      @(negedge clk_sys);
      n++;
      if (n > 20) begin
        n_fail++;
        $display("ERROR %0t no word taken within bound", $time);
        end_sim;
      end
    end
    @(negedge clk_sys);
    chk(exec_word, w);
    chk({12'h000, exec_class}, t[1] ? {12'h000, IWD_CLS_LIT} : {12'h000, t});
    chk(file_addr, w[6:0]);
    chk(dest_is_file, w[7]);
    chk({wr_w, wr_file}, (t == IWD_GRP_BYTE) ? {~w[7], w[7]} : 2'h0);
    chk(bit_index, w[9:7]);
    chk(bit_mask, 8'h01 << w[9:7]);
    chk(literal, (t == IWD_GRP_JUMP) ? w[10:0] : {3'h0, w[7:0]});
    chk(lit_is_11, t == IWD_GRP_JUMP);
    chk(phase, 2'h0);
    for (int k = 1; k < 4; k++) begin
      @(negedge clk_sys);
      chk(cycle_end, k == 3);
    end
    chk(fetch_req, !two);
    if (two) begin
      @(negedge clk_sys);
      chk({nop_cycle, wr_w, wr_file}, 3'h4);
      chk(exec_word, w);
      repeat (3) @(negedge clk_sys);
      chk(fetch_req, 1'b1);
    end
  endtask
  task automatic t_reset;
    chk(exec_word, 14'h0000);
    chk(wr_w, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_byte;
    for (int i = 0; i < 2; i++) run_word(i);
    $display("byte test done");
  endtask
  // Taken skips, a skip not taken, and a bit op with the condition up but no skip
  task automatic t_skip;
    for (int i = 2; i < 7; i++) run_word(i);
    $display("skip test done");
  endtask
  task automatic t_jump;
    for (int i = 7; i < 9; i++) run_word(i);
    $display("jump test done");
  endtask
  task automatic t_lit;
    for (int i = 9; i < 12; i++) run_word(i);
    $display("literal test done");
  endtask
  initial begin
    n_fail = 0;
    total_checks = 0;
    nrst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      u_iwd_fetch_model.mem[i] = (i < 12) ? PROG[i] : 14'h0000;
      u_iwd_fetch_model.skp[i] = (i < 12) ? SKPV[i] : 1'b0;
    end
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    t_reset;
    t_byte;
    t_skip;
    t_jump;
    t_lit;
    end_sim;
  end
endmodule
`default_nettype wire

// >>> test/iwd_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// Program store plus datapath stand-in facing the decoder
module iwd_fetch_model (
  input  wire logic                           clk_sys,
  input  wire logic                           nrst,
  input  wire logic [1:0]                     phase,
  input  wire logic                           fetch_req,
  output logic [iwd_pkg::IWD_WORD_W-1:0]      instr_word,
  output logic                                skip_true
);
  import iwd_pkg::*;
  logic [IWD_WORD_W-1:0] mem [0:15]; // Words in fetch order, loaded by the bench
  logic                  skp [0:15]; // Skip outcome of each word
  logic [3:0]            pc_reg;     // Next word to hand over
  logic                  take;       // Decoder takes a word at this edge
  assign take = (phase == 2'h3) && fetch_req;
  // Valid only when taken; inverse elsewhere so an early or late sample is caught
  assign instr_word = take ? mem[pc_reg] : ~mem[pc_reg];
  // Condition of the executing word, scrambled outside the last phase
  assign skip_true = (phase == 2'h3) ? skp[pc_reg - 4'h1] : ~skp[pc_reg - 4'h1];
  // Advance only on a taken word; a refused fetch keeps the pointer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pc_reg <= 4'h0;
    end else if (take) begin
      pc_reg <= pc_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire
